// ===== verilog/mode_ctrl_pkg.sv
// Constants and types shared by the operation mode controller
package mode_ctrl_pkg;

  localparam int          CHANNELS          = 8;
  localparam int          FRAME_BITS        = 16;
  localparam logic [4:0]  FRAME_BITS_COUNT  = 5'h10;

  // Operating mode, code equals the reported status field
  typedef enum logic [1:0] {
    MODE_IDLE   = 2'b00,
    MODE_LIMP   = 2'b01,
    MODE_ACTIVE = 2'b10,
    MODE_SLEEP  = 2'b11
  } op_mode_e;

  // Frame fields
  localparam int          WRITE_POS         = 15;
  localparam int          ADDR_MSB          = 14;
  localparam int          ADDR_LSB          = 12;
  localparam int          TER_POS           = 15;
  localparam int          MODE_MSB          = 14;
  localparam int          MODE_LSB          = 13;
  localparam int          UV_POS            = 12;
  localparam int          LOP_POS           = 11;

  // Register addresses
  localparam logic [2:0]  ADDR_CHANNEL_ON   = 3'h0;
  localparam logic [2:0]  ADDR_MAP_FIRST    = 3'h1;
  localparam logic [2:0]  ADDR_MAP_SECOND   = 3'h2;
  localparam logic [2:0]  ADDR_OPEN_LOAD    = 3'h3;
  localparam logic [2:0]  ADDR_HW_CONTROL   = 3'h4;
  localparam logic [2:0]  ADDR_ERROR_CLEAR  = 3'h5;
  localparam logic [2:0]  ADDR_MONITOR      = 3'h6;
  localparam logic [2:0]  ADDR_DIAG_READ    = 3'h7;

  // Hardware control bits
  localparam int          STAY_ACTIVE_POS   = 0;
  localparam int          SOFT_RESET_POS    = 1;

  // Reset values
  localparam logic [7:0]  CHANNEL_ON_RST    = 8'h00;
  localparam logic [7:0]  MAP_FIRST_RST     = 8'h04;
  localparam logic [7:0]  MAP_SECOND_RST    = 8'h08;
  localparam logic [7:0]  OPEN_LOAD_RST     = 8'h00;
  localparam logic [7:0]  LIMP_CHANNEL_MASK = 8'h0C;
  localparam int          LIMP_IN0_CHANNEL  = 2;
  localparam int          LIMP_IN1_CHANNEL  = 3;

  // Mode transition latency
  localparam int          CLOCK_NS          = 5;
  localparam int          TRANSITION_NS     = 20;
  localparam int          TRANSITION_CYC    = (TRANSITION_NS + CLOCK_NS - 1) / CLOCK_NS;
  localparam logic [3:0]  TRANSITION_COUNT  = 4'(TRANSITION_CYC);

endpackage : mode_ctrl_pkg

// ===== verilog/spi_frame_if.sv
// Frame carrier between the serial receiver and the mode core
`timescale 1ns/100ps
interface spi_frame_if;
  logic        frame_done;
  logic        frame_error;
  logic [15:0] frame_word;
  logic [15:0] response;

  modport rx   (output frame_done, output frame_error, output frame_word, input response);
  modport core (input frame_done, input frame_error, input frame_word, output response);
endinterface : spi_frame_if

// ===== verilog/spi_frame_rx.sv
// Serial frame receiver sampled on the system clock
`timescale 1ns/100ps
module spi_frame_rx
  import mode_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // Serial pins
  input  wire logic sclk_pin,
  input  wire logic cs_n_pin,
  input  wire logic mosi_pin,
  output logic      miso,
  output logic      miso_oe,
  // Frame carrier
  spi_frame_if.rx   link
);

  logic [2:0]  pin_s1_r;
  logic [2:0]  pin_s2_r;
  logic [1:0]  edge_r;
  logic [4:0]  count_r;
  logic [15:0] shift_in_r;
  logic [15:0] shift_out_r;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_fall;
  logic        cs_rise;

  // Two stage synchroniser for sclk, cs_n, mosi
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= 3'h2;
      pin_s2_r <= 3'h2;
      edge_r   <= 2'h2;
    end else begin
      pin_s1_r <= {mosi_pin, cs_n_pin, sclk_pin};
      pin_s2_r <= pin_s1_r;
      edge_r   <= pin_s2_r[1:0];
    end
  end

  assign sclk_rise = pin_s2_r[0] & ~edge_r[0];
  assign sclk_fall = ~pin_s2_r[0] & edge_r[0];
  assign cs_fall   = ~pin_s2_r[1] & edge_r[1];
  assign cs_rise   = pin_s2_r[1] & ~edge_r[1];

  // Shift in on rising sclk, out on falling sclk
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      count_r     <= 5'h00;
      shift_in_r  <= 16'h0000;
      shift_out_r <= 16'h0000;
      miso        <= 1'b0;
      miso_oe     <= 1'b0;
    end else if (cs_fall) begin
      count_r     <= 5'h00;
      shift_out_r <= link.response;
      miso        <= link.response[FRAME_BITS-1];
      miso_oe     <= 1'b1;
    end else if (cs_rise) begin
      miso_oe     <= 1'b0;
    end else if (!pin_s2_r[1]) begin
      if (sclk_rise) begin
        shift_in_r <= {shift_in_r[14:0], pin_s2_r[2]};
        count_r    <= (count_r == 5'h1F) ? count_r : count_r + 5'h01;
      end
      if (sclk_fall) begin
        miso        <= shift_out_r[FRAME_BITS-2];
        shift_out_r <= {shift_out_r[14:0], 1'b0};
      end
    end
  end

  // Frame end strobe with bit count check
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      link.frame_done  <= 1'b0;
      link.frame_error <= 1'b0;
      link.frame_word  <= 16'h0000;
    end else begin
      link.frame_done <= cs_rise;
      if (cs_rise) begin
        link.frame_error <= (count_r != FRAME_BITS_COUNT);
        link.frame_word  <= shift_in_r;
      end
    end
  end

endmodule : spi_frame_rx

// ===== verilog/operation_mode_controller.sv
// Operation mode controller: mode state, register file and channel gating
// Operation
// [R1] Power-up needs a supply present plus a direct input or standby-select high.
// [R2] Internal power-on follows analog supply operative or logic supply above low-power.
// [R3] Sleep holds all outputs off and registers at reset.
// [R4] Idle keeps channels off and disables diagnosis.
// [R5] Idle with logic supply keeps registers working and accepts frames.
// [R6] Idle never clears the channel error bits.
// [R7] Standby high plus any input or channel-on bit enters Active.
// [R8] Without stay-active, Active returns to Idle when inputs and channel bits are zero.
// [R9] Stay-active holds Active regardless of inputs and channel bits.
// [R10] Logic supply undervoltage with all inputs low goes to Idle.
// [R11] A high direct input enters Active even with both maps zero.
// [R12] Standby low with an input high enters Limp Home, driving the mapped channel.
// [R13] Limp Home answers reads and ignores all writes.
// [R14] Limp Home reports both supply flags as one.
// [R15] Limp Home reports mode field 01.
// [R16] First frame after entering Limp Home reports transmission error.
// [R17] Limp Home forces open-load test bits to zero.
// [R18] Limp Home keeps error and monitor bits working and readable.
// [R19] Limp Home holds other registers at defaults, unprogrammable.
// [R20] Limp Home drives only channels 2 and 3.
// [R21] Host avoids frames during Active and Limp Home transitions.
// [R22] Turn-on from other modes adds the mode transition latency.
// [R23] Supply flags clear only on first diagnosis read after recovery; the code also clears them on soft reset and in Sleep.
// [R24] Soft reset restores defaults but keeps channel error bits.
// [R25] Soft reset clears both supply flags.
// [R26] Standby low with all inputs low falls into Sleep.
// [R27] Mode held in a clocked state register; Sleep resets registers.
`timescale 1ns/100ps
module operation_mode_controller
  import mode_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Mode pins
  input  wire logic                standby_select_pin,
  input  wire logic [1:0]          direct_input_pins,
  // Supply monitors
  input  wire logic                analog_supply_present,
  input  wire logic                analog_supply_above_op,
  input  wire logic                analog_supply_uv,
  input  wire logic                logic_supply_present,
  input  wire logic                logic_supply_above_lop,
  input  wire logic                logic_supply_uv,
  // Serial pins
  input  wire logic                spi_sclk,
  input  wire logic                spi_cs_n,
  input  wire logic                spi_mosi,
  output logic                     spi_miso,
  output logic                     spi_miso_oe,
  // Output stage
  input  wire logic [CHANNELS-1:0] channel_error_events,
  input  wire logic [CHANNELS-1:0] output_monitor_bits,
  output logic      [CHANNELS-1:0] channel_drive,
  output logic                     diag_enable,
  // Status
  output logic      [1:0]          operating_mode,
  output logic                     power_on,
  output logic                     register_reset
);

  spi_frame_if link ();

  spi_frame_rx u_rx (
    .clock    (clock),
    .arst_n   (arst_n),
    .sclk_pin (spi_sclk),
    .cs_n_pin (spi_cs_n),
    .mosi_pin (spi_mosi),
    .miso     (spi_miso),
    .miso_oe  (spi_miso_oe),
    .link     (link.core)
  );

  logic [8:0]          pin_s1_r;
  logic [8:0]          pin_s2_r;
  op_mode_e            mode_r;
  op_mode_e            mode_nxt;
  logic [CHANNELS-1:0] channel_on_bits_r;
  logic [7:0]          input_map_first_r;
  logic [7:0]          input_map_second_r;
  logic [CHANNELS-1:0] open_load_test_bits_r;
  logic                stay_active_bit_r;
  logic                soft_reset_r;
  logic [CHANNELS-1:0] channel_error_bits_r;
  logic                uv_flag_r;
  logic                lop_flag_r;
  logic                limp_pending_r;
  logic [15:0]         response_r;
  logic [3:0]          settle_cnt_r;
  logic [CHANNELS-1:0] drive_nxt;
  logic [CHANNELS-1:0] mapped;
  logic [7:0]          read_data;
  logic                standby;
  logic [1:0]          in_pins;
  logic                any_in;
  logic                any_chan;
  logic                a_present;
  logic                a_above_op;
  logic                a_uv;
  logic                l_present;
  logic                l_above_lop;
  logic                l_uv;
  logic                power_up;
  logic                power_on_int;
  logic                spi_enable;
  logic                frame_accept;
  logic                write_ok;
  logic                diag_read;
  logic                regs_clear;
  logic                settled;
  logic [2:0]          frame_addr;
  logic [7:0]          frame_data;

  // Address match on a write
  function automatic logic write_to(input logic [2:0] addr, input logic [2:0] target, input logic ok);
    write_to = ok & (addr == target);
  endfunction : write_to

  // Pin and supply synchroniser
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_r <= 9'h000;
      pin_s2_r <= 9'h000;
    end else begin
      pin_s1_r <= {standby_select_pin, direct_input_pins, analog_supply_present, analog_supply_above_op,
                   analog_supply_uv, logic_supply_present, logic_supply_above_lop, logic_supply_uv};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {standby, in_pins, a_present, a_above_op, a_uv, l_present, l_above_lop, l_uv} = pin_s2_r;
  assign any_in       = |in_pins;
  assign any_chan     = |channel_on_bits_r;
  assign power_up     = (a_present | l_present) & (any_in | standby); // [R1]
  assign power_on_int = a_above_op | l_above_lop; // [R2]
  assign frame_addr   = link.frame_word[ADDR_MSB:ADDR_LSB];
  assign frame_data   = link.frame_word[7:0];
  assign spi_enable   = l_present & ~l_uv & (mode_r != MODE_SLEEP); // [R5]
  assign frame_accept = link.frame_done & spi_enable;
  assign write_ok     = frame_accept & link.frame_word[WRITE_POS] & ~link.frame_error
                        & (mode_r != MODE_LIMP); // [R13]
  assign diag_read    = frame_accept & ~link.frame_word[WRITE_POS] & ~link.frame_error
                        & (frame_addr == ADDR_DIAG_READ);
  assign regs_clear   = (mode_r == MODE_SLEEP) | ~l_present | l_uv | soft_reset_r
                        | (mode_r == MODE_LIMP); // [R3] [R19] [R27]

  // Next mode
  always_comb begin
    mode_nxt = mode_r;
    if (!power_on_int || !power_up) begin
      mode_nxt = MODE_SLEEP;
    end else if (!standby) begin
      mode_nxt = any_in ? MODE_LIMP : MODE_SLEEP; // [R12] [R26]
    end else begin
      unique case (mode_r)
        MODE_ACTIVE: begin
          if (l_uv && !any_in) begin
            mode_nxt = MODE_IDLE; // [R10]
          end else if (!stay_active_bit_r && !any_in && !any_chan) begin
            mode_nxt = MODE_IDLE; // [R8]
          end else begin
            mode_nxt = MODE_ACTIVE; // [R9]
          end
        end
        MODE_IDLE, MODE_SLEEP, MODE_LIMP: begin
          mode_nxt = (any_in || (any_chan && !l_uv)) ? MODE_ACTIVE : MODE_IDLE; // [R7] [R11]
        end
      endcase
    end
  end

  // Mode state
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_r <= MODE_SLEEP;
    end else begin
      mode_r <= mode_nxt; // [R27]
    end
  end

  // Control registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      channel_on_bits_r     <= CHANNEL_ON_RST;
      input_map_first_r     <= MAP_FIRST_RST;
      input_map_second_r    <= MAP_SECOND_RST;
      open_load_test_bits_r <= OPEN_LOAD_RST;
      stay_active_bit_r     <= 1'b0;
      soft_reset_r          <= 1'b0;
    end else begin
      soft_reset_r <= write_to(frame_addr, ADDR_HW_CONTROL, write_ok) & frame_data[SOFT_RESET_POS];
      if (regs_clear) begin
        channel_on_bits_r     <= CHANNEL_ON_RST; // [R24]
        input_map_first_r     <= MAP_FIRST_RST;
        input_map_second_r    <= MAP_SECOND_RST;
        open_load_test_bits_r <= OPEN_LOAD_RST; // [R17]
        stay_active_bit_r     <= 1'b0;
      end else begin
        if (write_to(frame_addr, ADDR_CHANNEL_ON, write_ok)) begin
          channel_on_bits_r <= frame_data;
        end
        if (write_to(frame_addr, ADDR_MAP_FIRST, write_ok)) begin
          input_map_first_r <= frame_data;
        end
        if (write_to(frame_addr, ADDR_MAP_SECOND, write_ok)) begin
          input_map_second_r <= frame_data;
        end
        if (write_to(frame_addr, ADDR_OPEN_LOAD, write_ok)) begin
          open_load_test_bits_r <= frame_data;
        end
        if (write_to(frame_addr, ADDR_HW_CONTROL, write_ok)) begin
          stay_active_bit_r <= frame_data[STAY_ACTIVE_POS];
        end
      end
    end
  end

  // Channel error bits: set wins, clear write only in Active, zeroed in Sleep, kept by soft reset
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      channel_error_bits_r <= 8'h00;
    end else if (mode_r == MODE_SLEEP) begin
      channel_error_bits_r <= 8'h00; // [R3]
    end else begin
      channel_error_bits_r <= (channel_error_bits_r
        & ~({8{write_to(frame_addr, ADDR_ERROR_CLEAR, write_ok) & (mode_r == MODE_ACTIVE)}} & frame_data))
        | (channel_error_events & {8{diag_enable}}); // [R6] [R18] [R24]
    end
  end

  // Supply flags: set wins over read or soft reset clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      uv_flag_r  <= 1'b0;
      lop_flag_r <= 1'b0;
    end else if (mode_r == MODE_SLEEP) begin
      uv_flag_r  <= 1'b0;
      lop_flag_r <= 1'b0;
    end else begin
      uv_flag_r  <= a_uv | (uv_flag_r & ~(diag_read | soft_reset_r)); // [R23] [R25]
      lop_flag_r <= ~l_above_lop | (lop_flag_r & ~(diag_read | soft_reset_r)); // [R23] [R25]
    end
  end

  // Pending error report after Limp Home entry
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      limp_pending_r <= 1'b0;
    end else if (mode_nxt == MODE_LIMP && mode_r != MODE_LIMP) begin
      limp_pending_r <= 1'b1; // [R16]
    end else if (frame_accept || mode_r != MODE_LIMP) begin
      limp_pending_r <= 1'b0;
    end
  end

  // Read data selection
  always_comb begin
    unique case (frame_addr)
      ADDR_CHANNEL_ON:  read_data = channel_on_bits_r;
      ADDR_MAP_FIRST:   read_data = input_map_first_r;
      ADDR_MAP_SECOND:  read_data = input_map_second_r;
      ADDR_OPEN_LOAD:   read_data = open_load_test_bits_r;
      ADDR_HW_CONTROL:  read_data = {7'h00, stay_active_bit_r};
      ADDR_ERROR_CLEAR: read_data = channel_error_bits_r;
      ADDR_MONITOR:     read_data = output_monitor_bits; // [R18]
      ADDR_DIAG_READ:   read_data = channel_error_bits_r;
    endcase
  end

  // Response for the next frame
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      response_r <= 16'h0000;
    end else if (frame_accept) begin
      response_r <= {link.frame_error | limp_pending_r, mode_r,
                     uv_flag_r | (mode_r == MODE_LIMP), lop_flag_r | (mode_r == MODE_LIMP),
                     3'h0, read_data}; // [R13] [R14] [R15] [R16]
    end
  end

  assign link.response = response_r;

  // Mode transition latency
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_r <= TRANSITION_COUNT;
    end else if (mode_r != MODE_ACTIVE && mode_r != MODE_LIMP) begin
      settle_cnt_r <= TRANSITION_COUNT; // [R22]
    end else if (settle_cnt_r != 4'h0) begin
      settle_cnt_r <= settle_cnt_r - 4'h1;
    end
  end

  assign settled = (settle_cnt_r == 4'h0);
  assign mapped  = ({8{in_pins[0]}} & input_map_first_r) | ({8{in_pins[1]}} & input_map_second_r);

  // Channel drive per mode
  always_comb begin
    drive_nxt = 8'h00; // [R3] [R4]
    if (settled && mode_r == MODE_ACTIVE) begin
      drive_nxt = a_uv ? mapped : (channel_on_bits_r | mapped);
    end else if (settled && mode_r == MODE_LIMP) begin
      drive_nxt[LIMP_IN0_CHANNEL] = in_pins[0]; // [R12]
      drive_nxt[LIMP_IN1_CHANNEL] = in_pins[1];
      drive_nxt = drive_nxt & LIMP_CHANNEL_MASK; // [R20]
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      channel_drive  <= 8'h00;
      diag_enable    <= 1'b0;
      power_on       <= 1'b0;
      register_reset <= 1'b1;
    end else begin
      channel_drive  <= drive_nxt;
      diag_enable    <= (mode_r == MODE_ACTIVE) | (mode_r == MODE_LIMP); // [R4] [R18]
      power_on       <= power_on_int; // [R2]
      register_reset <= regs_clear;
    end
  end

  assign operating_mode = mode_r;

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  property p_sleep_off;
    (mode_r == MODE_SLEEP) |=> (channel_drive == 8'h00) && (channel_on_bits_r == CHANNEL_ON_RST);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Sleep left a channel or register set"); // [R3]

  property p_idle_off;
    (mode_r == MODE_IDLE) |=> (channel_drive == 8'h00) && !diag_enable;
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("Idle drove a channel or diagnosis"); // [R4]

  property p_idle_err_kept;
    (mode_r == MODE_IDLE) ##1 (mode_r == MODE_IDLE) |-> ((channel_error_bits_r & $past(channel_error_bits_r))
      == $past(channel_error_bits_r));
  endproperty
  a_idle_err_kept: assert property (p_idle_err_kept) else $error("Error bit cleared in Idle"); // [R6]

  property p_enter_active;
    (mode_r == MODE_IDLE) && standby && (any_in || (any_chan && !l_uv)) && power_on_int && power_up
      |=> (mode_r == MODE_ACTIVE);
  endproperty
  a_enter_active: assert property (p_enter_active) else $error("Active not entered"); // [R7]

  property p_back_idle;
    (mode_r == MODE_ACTIVE) && standby && power_on_int && power_up && !stay_active_bit_r && !any_in && !any_chan
      |=> (mode_r == MODE_IDLE);
  endproperty
  a_back_idle: assert property (p_back_idle) else $error("Active did not return to Idle"); // [R8]

  property p_stay_active;
    (mode_r == MODE_ACTIVE) && standby && power_on_int && power_up && stay_active_bit_r && !l_uv
      |=> (mode_r == MODE_ACTIVE);
  endproperty
  a_stay_active: assert property (p_stay_active) else $error("Stay-active did not hold Active"); // [R9]

  property p_limp_enter;
    !standby && any_in && power_on_int && power_up |=> (mode_r == MODE_LIMP);
  endproperty
  a_limp_enter: assert property (p_limp_enter) else $error("Limp Home not entered"); // [R12]

  property p_limp_mask;
    (mode_r == MODE_LIMP) |=> ((channel_drive & ~LIMP_CHANNEL_MASK) == 8'h00) && (open_load_test_bits_r == 8'h00);
  endproperty
  a_limp_mask: assert property (p_limp_mask) else $error("Limp Home drove a forbidden channel"); // [R17] [R20]

  property p_limp_status;
    (mode_r == MODE_LIMP) && frame_accept |=> response_r[UV_POS] && response_r[LOP_POS]
      && (response_r[MODE_MSB:MODE_LSB] == 2'b01);
  endproperty
  a_limp_status: assert property (p_limp_status) else $error("Limp Home status wrong"); // [R14] [R15]

  property p_limp_ter;
    (mode_r == MODE_LIMP) && limp_pending_r && frame_accept |=> response_r[TER_POS] && !limp_pending_r;
  endproperty
  a_limp_ter: assert property (p_limp_ter) else $error("First Limp Home frame lacks error flag"); // [R16]

  property p_latency;
    $rose(mode_r == MODE_ACTIVE) && ($past(mode_r) == MODE_IDLE) |-> (channel_drive == 8'h00) [*4];
  endproperty
  a_latency: assert property (p_latency) else $error("Channel on before transition latency"); // [R22]

  c_active: cover property ($rose(mode_r == MODE_ACTIVE));
  c_limp: cover property ($rose(mode_r == MODE_LIMP) ##[1:1000] frame_accept);
  c_back_idle: cover property ((mode_r == MODE_ACTIVE) ##1 (mode_r == MODE_IDLE));
  c_diag_read: cover property (diag_read && uv_flag_r);

endmodule : operation_mode_controller

// ===== dv/spi_host_model.sv
// Serial host model sending frames to the controller
`timescale 1ns/100ps
module spi_host_model (
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  input  wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // One frame, MSB first, clock idle low, caller keeps clear of mode changes
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = tx[i];
      #40 sclk = 1'b1;
      rx[i] = miso;
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = ~mosi;
    #80;
  endtask : xfer
endmodule : spi_host_model

// ===== dv/operation_mode_controller_tb_top.sv
// Testbench for the operation mode controller
`timescale 1ns/100ps
module operation_mode_controller_tb_top;
  import mode_ctrl_pkg::*;
  logic        clock, arst_n, standby, lsup_uv, sclk, cs_n, mosi, miso, miso_oe, miso_wire;
  logic        diag_en, pwr_on, reg_rst;
  logic [1:0]  inputs, mode;
  logic [7:0]  drive, mon, err_ev;
  logic [15:0] rx;
  int          n_fail, n_compared, cycles;
  // Pull-up on the released data line
  assign miso_wire = miso_oe ? miso : 1'b1;
  spi_host_model spi_host_model_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso_wire));
  operation_mode_controller operation_mode_controller_inst (
    .clock(clock), .arst_n(arst_n), .standby_select_pin(standby), .direct_input_pins(inputs),
    .analog_supply_present(1'b1), .analog_supply_above_op(1'b1), .analog_supply_uv(1'b0),
    .logic_supply_present(1'b1), .logic_supply_above_lop(1'b1), .logic_supply_uv(lsup_uv),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe),
    .channel_error_events(err_ev), .output_monitor_bits(mon), .channel_drive(drive),
    .diag_enable(diag_en), .operating_mode(mode), .power_on(pwr_on), .register_reset(reg_rst));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Wait for a mode under a bound, let outputs settle, compare
  task automatic settle(input logic [1:0] exp_mode);
    for (int i = 0; i < 30 && mode !== exp_mode; i++) @(negedge clock);
    repeat (12) @(negedge clock);
    check("mode", 16'(mode), 16'(exp_mode));
  endtask : settle
  task automatic frame(input logic [15:0] w);
    @(negedge clock);
    spi_host_model_inst.xfer(w, rx);
  endtask : frame
  initial begin
    arst_n = 1'b0;
    standby = 1'b0;
    inputs = 2'b00;
    lsup_uv = 1'b0;
    mon = 8'hA5;
    err_ev = 8'h00;
    n_fail = 0;
    n_compared = 0;
    cycles = 0;
    repeat (16) @(negedge clock);
    arst_n = 1'b1;
    settle(MODE_SLEEP);
    check("reset", {7'h00, reg_rst, drive}, 16'h0100);
    standby = 1'b1;
    settle(MODE_IDLE);
    check("idle", {6'h00, pwr_on, diag_en, drive}, 16'h0200);
    inputs = 2'b01;
    for (int i = 0; i < 10 && mode !== MODE_ACTIVE; i++) @(negedge clock);
    repeat (4) @(negedge clock);
    check("latency", 16'(drive), 16'h0000);
    settle(MODE_ACTIVE);
    check("pin drive", 16'(drive), 16'h0004);
    inputs = 2'b00;
    settle(MODE_IDLE);
    frame(16'h8001);
    settle(MODE_ACTIVE);
    check("bit drive", 16'(drive), 16'h0001);
    err_ev = 8'h10;
    repeat (2) @(negedge clock);
    err_ev = 8'h00;
    frame(16'h0000);
    frame(16'h0000);
    check("active read", rx, 16'h4001);
    frame(16'h8000);
    settle(MODE_IDLE);
    frame(16'h1000);
    frame(16'hD0FF);
    check("idle read", rx, 16'h0004);
    frame(16'h7000);
    frame(16'h5000);
    check("idle errors", rx, 16'h0010);
    frame(16'hC001);
    settle(MODE_IDLE);
    inputs = 2'b10;
    repeat (12) @(negedge clock);
    inputs = 2'b00;
    settle(MODE_ACTIVE);
    lsup_uv = 1'b1;
    settle(MODE_IDLE);
    lsup_uv = 1'b0;
    repeat (20) @(negedge clock);
    frame(16'hC000);
    settle(MODE_IDLE);
    standby = 1'b0;
    inputs = 2'b01;
    settle(MODE_LIMP);
    check("limp drive", 16'(drive), 16'h0004);
    frame(16'h80FF);
    frame(16'h0000);
    check("limp first", rx, 16'hB800);
    frame(16'h6000);
    check("limp readback", rx, 16'h3800);
    frame(16'h6000);
    check("limp monitor", rx, 16'h38A5);
    check("limp write", 16'(drive), 16'h0004);
    inputs = 2'b11;
    repeat (12) @(negedge clock);
    check("limp pair", 16'(drive), 16'h000C);
    inputs = 2'b00;
    settle(MODE_SLEEP);
    end_of_test();
  end
endmodule : operation_mode_controller_tb_top
